// *** design/charger_ctrl.v ***
// What this block does
// - Power-good pulls low only with input above low, above sleep level, below overvoltage.
// - Status released high when charge done, asleep, or sense pin disabled.
// - Status held low during any charge cycle, recharge included.
// - Status toggles at 1Hz while any fault is present.
// - Deglitched input overvoltage stops charging, suspends timer, enters standby.
// - Input overvoltage recovery resumes charge and timer from suspended count.
// - Output overvoltage stops charging at once, suspends timer, recovers automatically.
// - Deglitched output overcurrent latches off until input or sense toggle.
// - Output overcurrent clears the safety timer count to zero.
// - Thermal regulation blocks termination and halves timer rate.
// - Thermal shutdown turns regulator off; resumes after die cools.
// - Input low or sense disabled gives shutdown with outputs high impedance.
// - Leaving shutdown goes to sleep or active according to whether input is above sleep level.
// - Input below output plus sleep offset keeps sleep, no charging.
// - Active charging only with sense enabled and input above both thresholds.
// - Standby after termination or recoverable fault, left on recharge or fault clear.
// - Input/output overvoltage, hot and cold are recoverable, clear automatically.
// - Overcurrent and program pin faults latch until an outside toggle.
// - Timer expiry fault after 30 minutes precharge or 10 hours fast charge.
// - Terminate above recharge with low current; restart below recharge.
// - Battery temperature out of window stops, standby, blinks, resumes when normal.
// - Sense disable release acts as supply toggle, clearing latches and timer.
`timescale 1ns/1ps
`include "charger_consts.vh"
module charger_ctrl #(
	parameter [31:0] SEC_CYC = `SEC_CYC,
	parameter [31:0] PRE_SEC = `PRE_TIMER_SEC,
	parameter [31:0] FAST_SEC = `FAST_TIMER_SEC,
	parameter [31:0] BLINK_HALF = `BLINK_HALF_CYC
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_ce,
	input wire i_input_above_low,
	input wire i_input_above_sleep,
	input wire i_input_overvoltage,
	input wire i_output_overvoltage,
	input wire i_output_overcurrent,
	input wire i_thermal_regulation_active,
	input wire i_thermal_shutdown_active,
	input wire i_battery_too_warm,
	input wire i_battery_too_cool,
	input wire i_sense_above_disable,
	input wire i_output_above_recharge,
	input wire i_current_below_term,
	input wire i_output_above_lowv,
	input wire i_current_program_short,
	input wire i_voltage_program_bad,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hsel,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire o_hresp,
	output wire o_input_good_n_o,
	output wire o_input_good_n_oe,
	output wire o_status_o,
	output wire o_status_oe,
	output wire o_charge_enable,
	output wire [2:0] o_mode,
	output wire o_safety_timer_expired
);
	// ****************************************
	// Flag synchronisers
	// ****************************************
	wire [14:0] s;
	flag_sync #(.W(15)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_async({i_input_above_low, i_input_above_sleep, i_input_overvoltage, i_output_overvoltage,
			i_output_overcurrent, i_thermal_regulation_active, i_thermal_shutdown_active,
			i_battery_too_warm, i_battery_too_cool, i_sense_above_disable, i_output_above_recharge,
			i_current_below_term, i_output_above_lowv, i_current_program_short, i_voltage_program_bad}),
		.o_sync(s)
	);
	wire in_low_ok = s[14];
	wire in_sleep_ok = s[13];
	wire in_ov = s[12];
	wire out_ov = s[11];
	wire out_oc = s[10];
	wire thermal_regulation_active = s[9];
	wire thermal_shutdown_active = s[8];
	wire hot = s[7];
	wire cold = s[6];
	wire ts_en = s[5];
	wire above_rechg = s[4];
	wire below_term = s[3];
	wire above_lowv = s[2];
	wire current_program_pin_short = s[1];
	wire voltage_program_pin_bad = s[0];

	wire blink;
	blink_gen #(.HALF_CYC(BLINK_HALF)) u_blink (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.o_blink(blink)
	);

	// ****************************************
	// Register bus
	// ****************************************
	reg [31:0] ctrl_r;
	reg wr_pend_r;
	reg rd_pend_r;
	reg [7:0] addr_r;
	wire take = i_hsel & i_hready & i_htrans[1];
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	// Software toggle request: same effect as an outside supply toggle
	wire sw_retrig = wr_pend_r & (addr_r == `REG_CTRL) & i_hwdata[`CTRL_RETRIG_BIT];
	wire force_off = ctrl_r[`CTRL_FORCE_OFF_BIT];

	// ****************************************
	// Deglitch counters
	// ****************************************
	reg [15:0] ovp_cnt_r;
	reg [15:0] ocp_cnt_r;
	wire in_ov_q = (ovp_cnt_r == `OVP_DGL_CYC);
	wire oc_q = (ocp_cnt_r == `OCP_DGL_CYC);

	function [15:0] dgl_next;
		input flag;
		input [15:0] cnt;
		input [15:0] lim;
		begin
			if (!flag)
				dgl_next = 16'h0000;
			else if (cnt == lim)
				dgl_next = cnt;
			else
				dgl_next = cnt + 16'h0001;
		end
	endfunction

	// ****************************************
	// Mode state machine
	// ****************************************
	reg [2:0] mode_r;
	reg [2:0] mode_nxt;
	reg latch_r;
	reg done_r;
	reg expired_r;
	reg ts_en_d_r;
	reg lowv_d_r;
	reg [31:0] sec_cnt_r;
	reg [31:0] tmr_r;
	reg half_r;

	wire powered = in_low_ok & ts_en;
	wire retrig = (ts_en & ~ts_en_d_r) | sw_retrig;
	wire recov = in_ov_q | out_ov | hot | cold;
	wire latch_cause = oc_q | current_program_pin_short | voltage_program_pin_bad;
	wire term = above_rechg & below_term & ~thermal_regulation_active;
	wire limit_hit = above_lowv ? (tmr_r >= FAST_SEC) : (tmr_r >= PRE_SEC);

	always @* begin
		mode_nxt = mode_r;
		case (mode_r)
			`MODE_SHUTDOWN: begin
				if (powered)
					mode_nxt = in_sleep_ok ? `MODE_ACTIVE : `MODE_SLEEP;
			end
			`MODE_SLEEP: begin
				if (in_sleep_ok)
					mode_nxt = `MODE_ACTIVE;
			end
			`MODE_ACTIVE: begin
				if (latch_cause || expired_r)
					mode_nxt = `MODE_FAULT;
				else if (recov || term || thermal_shutdown_active || force_off)
					mode_nxt = `MODE_STANDBY;
			end
			`MODE_STANDBY: begin
				if (latch_cause)
					mode_nxt = `MODE_FAULT;
				else if (!recov && !thermal_shutdown_active && !force_off && !(done_r && above_rechg))
					mode_nxt = `MODE_ACTIVE;
			end
			`MODE_FAULT: mode_nxt = `MODE_FAULT;
			default: mode_nxt = `MODE_SHUTDOWN;
		endcase
		if (!powered)
			mode_nxt = `MODE_SHUTDOWN;
		else if (!in_sleep_ok && mode_r != `MODE_FAULT)
			mode_nxt = `MODE_SLEEP;
		if (retrig)
			mode_nxt = `MODE_SHUTDOWN;
	end

	// Timer runs only in active charging; suspended elsewhere, with shutdown clearing the count
	wire tick = (sec_cnt_r >= SEC_CYC - 32'h0000_0001);
	wire charging = (mode_r == `MODE_ACTIVE);

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			mode_r <= `MODE_SHUTDOWN;
			latch_r <= 1'b0;
			done_r <= 1'b0;
			expired_r <= 1'b0;
			ts_en_d_r <= 1'b0;
			lowv_d_r <= 1'b0;
			sec_cnt_r <= 32'h0000_0000;
			tmr_r <= 32'h0000_0000;
			half_r <= 1'b0;
			ovp_cnt_r <= 16'h0000;
			ocp_cnt_r <= 16'h0000;
			ctrl_r <= `CTRL_RESET;
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
			o_hrdata <= 32'h0000_0000;
		end else if (i_ce) begin
			mode_r <= mode_nxt;
			ts_en_d_r <= ts_en;
			lowv_d_r <= above_lowv;
			ovp_cnt_r <= dgl_next(in_ov, ovp_cnt_r, `OVP_DGL_CYC);
			ocp_cnt_r <= dgl_next(out_oc, ocp_cnt_r, `OCP_DGL_CYC);
			if (mode_nxt == `MODE_FAULT)
				latch_r <= 1'b1;
			if (charging && term)
				done_r <= 1'b1;
			else if (!above_rechg)
				done_r <= 1'b0;
			if (charging && limit_hit)
				expired_r <= 1'b1;
			if (mode_r == `MODE_STANDBY && done_r && !above_rechg)
				tmr_r <= 32'h0000_0000;
			if (oc_q || retrig || !powered || (above_lowv != lowv_d_r)) begin
				tmr_r <= 32'h0000_0000;
				sec_cnt_r <= 32'h0000_0000;
				// Half-rate phase restarts with the count, so a regulated cycle lasts exactly twice as long
				half_r <= 1'b0;
			end else if (charging) begin
				sec_cnt_r <= tick ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
				if (tick) begin
					half_r <= ~half_r;
					if (!thermal_regulation_active || half_r)
						tmr_r <= tmr_r + 32'h0000_0001;
				end
			end
			if (retrig || !powered) begin
				latch_r <= 1'b0;
				done_r <= 1'b0;
				expired_r <= 1'b0;
			end
			wr_pend_r <= take & i_hwrite;
			rd_pend_r <= take & ~i_hwrite;
			if (take)
				addr_r <= i_haddr[7:0];
			if (wr_pend_r && addr_r == `REG_CTRL)
				ctrl_r <= {30'h0000_0000, i_hwdata[1], 1'b0};
			if (take && !i_hwrite) begin
				case (i_haddr[7:0])
					`REG_CTRL: o_hrdata <= ctrl_r;
					`REG_FLAGS: o_hrdata <= {17'h0_0000, s};
					`REG_STATUS: o_hrdata <= {26'h000_0000, expired_r, latch_r, done_r, mode_r};
					`REG_TIMER: o_hrdata <= tmr_r;
					default: o_hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	wire any_fault = (mode_r == `MODE_FAULT) | expired_r | recov | latch_cause;
	wire stat_low = any_fault ? blink : (charging | (mode_r == `MODE_STANDBY & ~done_r));
	wire pg_low = in_low_ok & in_sleep_ok & ~in_ov_q;
	// Low output enable drives the pin; shutdown releases both
	assign o_input_good_n_o = 1'b0;
	assign o_input_good_n_oe = ~(pg_low & ts_en & (mode_r != `MODE_SHUTDOWN));
	assign o_status_o = 1'b0;
	assign o_status_oe = ~(stat_low & mode_r != `MODE_SHUTDOWN & mode_r != `MODE_SLEEP);
	assign o_charge_enable = charging & ~thermal_shutdown_active & ~in_ov_q & ~out_ov;
	assign o_mode = mode_r;
	assign o_safety_timer_expired = expired_r;
endmodule // charger_ctrl

// *** pkg/charger_consts.vh ***
`ifndef CHARGER_CONSTS_VH
`define CHARGER_CONSTS_VH
// ****************************************
// Clock and timing
// ****************************************
`define CLK_HZ 40000000
`define BLINK_HZ 1
`define BLINK_HALF_CYC ((`CLK_HZ / `BLINK_HZ) / 2)
`define PRE_TIMER_MIN 30
`define FAST_TIMER_HR 10
`define SEC_CYC `CLK_HZ
`define PRE_TIMER_SEC (`PRE_TIMER_MIN * 60)
`define FAST_TIMER_SEC (`FAST_TIMER_HR * 3600)
`define OVP_DGL_CYC 16'h0FA0
`define OCP_DGL_CYC 16'h0FA0
// ****************************************
// Bus map
// ****************************************
`define REG_CTRL 8'h00
`define REG_FLAGS 8'h04
`define REG_STATUS 8'h08
`define REG_TIMER 8'h0C
`define CTRL_RESET 32'h0000_0000
`define CTRL_RETRIG_BIT 0
`define CTRL_FORCE_OFF_BIT 1
// ****************************************
// Modes
// ****************************************
`define MODE_SHUTDOWN 3'h0
`define MODE_SLEEP 3'h1
`define MODE_ACTIVE 3'h2
`define MODE_STANDBY 3'h3
`define MODE_FAULT 3'h4
`endif

// *** design/flag_sync.v ***
`timescale 1ns/1ps
`include "charger_consts.vh"
module flag_sync #(
	parameter W = 13
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_ce,
	input wire [W-1:0] i_async,
	output reg [W-1:0] o_sync
);
	reg [W-1:0] meta_r;
	// Two stages; the first is read by nothing else
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			meta_r <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else if (i_ce) begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule // flag_sync

// *** design/blink_gen.v ***
`timescale 1ns/1ps
`include "charger_consts.vh"
module blink_gen #(
	parameter [31:0] HALF_CYC = `BLINK_HALF_CYC
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_ce,
	output reg o_blink
);
	reg [31:0] cnt_r;
	// Equal halves so the LED duty is 50 percent
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cnt_r <= 32'h0000_0000;
			o_blink <= 1'b0;
		end else if (i_ce) begin
			if (cnt_r >= HALF_CYC - 32'h0000_0001) begin
				cnt_r <= 32'h0000_0000;
				o_blink <= ~o_blink;
			end else begin
				cnt_r <= cnt_r + 32'h0000_0001;
			end
		end
	end
endmodule // blink_gen

// *** bench/charger_ctrl_monitor.sv ***
`timescale 1ns/1ps
`include "charger_consts.vh"
// ****
// Mode and indicator checker
// ****
module charger_ctrl_monitor (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_output_overvoltage,
	input wire i_thermal_shutdown_active,
	input wire o_input_good_n_oe,
	input wire o_status_oe,
	input wire o_charge_enable,
	input wire [2:0] o_mode,
	input wire o_safety_timer_expired
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Two-flop flag sync plus one state update: allow a short settle
	sequence s_ovp_held;
		i_output_overvoltage [*3];
	endsequence
	sequence s_blink_edge;
		$changed(o_status_oe) && o_mode == `MODE_FAULT && $past(o_mode) == `MODE_FAULT;
	endsequence
	sequence s_fault_run;
		(o_mode == `MODE_FAULT) [*8];
	endsequence
	property p_pg_awake;
		!o_input_good_n_oe [*3] |-> o_mode != `MODE_SHUTDOWN && o_mode != `MODE_SLEEP;
	endproperty
	// A fault seen now moves the mode only at the next edge, so judge the cycle that stayed active
	property p_stat_active;
		(o_mode == `MODE_ACTIVE) [*2] |-> !$past(o_status_oe);
	endproperty
	property p_stat_idle;
		(o_mode == `MODE_SLEEP || o_mode == `MODE_SHUTDOWN) [*2] |-> o_status_oe;
	endproperty
	property p_shut_hiz;
		(o_mode == `MODE_SHUTDOWN) [*2] |-> o_input_good_n_oe && !o_charge_enable;
	endproperty
	property p_enable_active;
		o_charge_enable |-> o_mode == `MODE_ACTIVE;
	endproperty
	property p_blink;
		s_blink_edge ##1 s_fault_run |-> $changed(o_status_oe);
	endproperty
	property p_ovp_stop;
		s_ovp_held |-> ##[0:2] !o_charge_enable;
	endproperty
	property p_thermal_shutdown_active_off;
		i_thermal_shutdown_active [*5] |-> !o_charge_enable;
	endproperty
	property p_expired_off;
		o_safety_timer_expired [*2] |-> !o_charge_enable && o_mode != `MODE_ACTIVE;
	endproperty
	a_pg_awake: assert property (p_pg_awake) else $error("input good while idle");
	a_stat_active: assert property (p_stat_active) else $error("status not low");
	a_stat_idle: assert property (p_stat_idle) else $error("status not released");
	a_shut_hiz: assert property (p_shut_hiz) else $error("pins driven in shutdown");
	a_enable_active: assert property (p_enable_active) else $error("charging outside active");
	a_blink: assert property (p_blink) else $error("blink half period wrong");
	a_ovp_stop: assert property (p_ovp_stop) else $error("output overvoltage ignored");
	a_thermal_shutdown_active_off: assert property (p_thermal_shutdown_active_off) else $error("charging while too hot");
	a_expired_off: assert property (p_expired_off) else $error("charging after expiry");
endmodule // charger_ctrl_monitor

bind charger_ctrl charger_ctrl_monitor u_charger_ctrl_monitor (.i_ref_clk, .i_rst_n, .i_output_overvoltage,
	.i_thermal_shutdown_active, .o_input_good_n_oe, .o_status_oe, .o_charge_enable, .o_mode, .o_safety_timer_expired);

// *** bench/supply_battery_model.sv ***
`timescale 1ns/1ps
// ****
// Supply, battery and indicator model
// ****
module supply_battery_model (
	input wire i_ref_clk,
	input wire [14:0] i_scene,
	input wire i_toggle,
	input wire i_pg_o,
	input wire i_pg_oe,
	input wire i_stat_o,
	input wire i_stat_oe,
	output wire [14:0] o_flags,
	output wire o_pg_level,
	output wire o_stat_level
);
	logic [2:0] low_r = 3'h0;
	// Sense pin held low long enough to get through the synchroniser
	always @(posedge i_ref_clk) begin
		if (i_toggle) begin
			low_r <= 3'h6;
		end else if (low_r != 3'h0) begin
			low_r <= low_r - 3'h1;
		end
	end
	assign o_flags = i_scene & ~{9'h000, low_r != 3'h0, 5'h00};
	// Pull-ups: a released line reads high
	assign o_pg_level = i_pg_oe ? 1'b1 : i_pg_o;
	assign o_stat_level = i_stat_oe ? 1'b1 : i_stat_o;
endmodule // supply_battery_model

// *** bench/charger_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`include "charger_consts.vh"
// ****
// Charger controller bench
// ****
module charger_ctrl_tb_top;
	localparam [14:0] NORMAL = 15'h6024;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic toggle = 1'b0;
	logic ce = 1'b1;
	logic hwrite = 1'b0;
	logic hsel = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [14:0] scene = NORMAL;
	logic [14:0] s;
	logic [15:0] lfsr = 16'h0055;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [14:0] faults [0:3] = '{15'h1000, 15'h0800, 15'h0080, 15'h0040};
	logic [14:0] latches [0:2] = '{15'h0400, 15'h0002, 15'h0001};
	wire [14:0] f;
	wire [31:0] hrdata;
	wire [2:0] mode;
	wire hrdy, hresp, pg_o, pg_oe, st_o, st_oe, chg_en, expired, pg_lvl, st_lvl;
	int n_fail = 0;
	int compares = 0;
	always #12.5 clk = ~clk;
	charger_ctrl #(.SEC_CYC(32'h0000_03E8), .PRE_SEC(32'h0000_0005), .FAST_SEC(32'h0000_000A),
		.BLINK_HALF(32'h0000_0008)) u_charger_ctrl (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_input_above_low(f[14]), .i_input_above_sleep(f[13]), .i_input_overvoltage(f[12]),
		.i_output_overvoltage(f[11]), .i_output_overcurrent(f[10]), .i_thermal_regulation_active(f[9]),
		.i_thermal_shutdown_active(f[8]), .i_battery_too_warm(f[7]), .i_battery_too_cool(f[6]),
		.i_sense_above_disable(f[5]), .i_output_above_recharge(f[4]), .i_current_below_term(f[3]),
		.i_output_above_lowv(f[2]), .i_current_program_short(f[1]), .i_voltage_program_bad(f[0]),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hsel(hsel), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
		.o_input_good_n_o(pg_o), .o_input_good_n_oe(pg_oe), .o_status_o(st_o), .o_status_oe(st_oe),
		.o_charge_enable(chg_en), .o_mode(mode), .o_safety_timer_expired(expired));
	supply_battery_model u_supply_battery_model (.i_ref_clk(clk), .i_scene(scene), .i_toggle(toggle),
		.i_pg_o(pg_o), .i_pg_oe(pg_oe), .i_stat_o(st_o), .i_stat_oe(st_oe), .o_flags(f),
		.o_pg_level(pg_lvl), .o_stat_level(st_lvl));
	function [15:0] lfsr_next(input [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function [2:0] exp_mode(input [14:0] v);
		if (!v[14] || !v[5]) return `MODE_SHUTDOWN;
		if (!v[13]) return `MODE_SLEEP;
		if ((v & 15'h18C0) != 15'h0000) return `MODE_STANDBY;
		return `MODE_ACTIVE;
	endfunction
	task results;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Zero wait states expected, but every wait stays bounded
	task bus(input [31:0] a, input w, input [31:0] wd);
		int n;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsel <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 100);
		rdata = hrdata;
		if (n >= 100) begin
			n_fail++;
			results;
		end
	endtask
	task check_blink;
		int k;
		logic p;
		k = 0;
		p = st_lvl;
		repeat (32) begin
			@(posedge clk);
			if (st_lvl !== p) k++;
			p = st_lvl;
		end
		chk(k, 4);
	endtask
	task poke;
		toggle <= 1'b1;
		cyc(1);
		toggle <= 1'b0;
		cyc(20);
	endtask
	task settle(input [14:0] sc, input int w, input [2:0] m);
		scene <= sc;
		cyc(w);
		chk(mode, m);
		chk(chg_en, m == `MODE_ACTIVE && !sc[8]);
		chk(pg_lvl, !(sc[14] && sc[13] && !sc[12] && sc[5]));
		if (m == `MODE_STANDBY && (sc & 15'h18C0) != 15'h0000) check_blink;
		else chk(st_lvl, m != `MODE_ACTIVE);
		bus(32'h0000_0004, 1'b0, 32'h0000_0000);
		chk(rdata, {17'h00000, sc});
		chk(hresp, 1'b0);
		$display("scene %h checked", sc);
	endtask
	initial begin
		cyc(6);
		rst_n <= 1'b1;
		settle(NORMAL, 12, `MODE_ACTIVE);
		settle(15'h4024, 12, `MODE_SLEEP);
		settle(15'h6004, 12, `MODE_SHUTDOWN);
		foreach (faults[i]) begin
			settle(NORMAL | faults[i], faults[i][12] ? 4020 : 12, `MODE_STANDBY);
			settle(NORMAL, 12, `MODE_ACTIVE);
		end
		settle(15'h623C, 12, `MODE_ACTIVE);
		settle(15'h603C, 12, `MODE_STANDBY);
		settle(15'h6034, 12, `MODE_STANDBY);
		settle(NORMAL, 12, `MODE_ACTIVE);
		scene <= 15'h6124;
		cyc(12);
		chk(chg_en, 1'b0);
		settle(NORMAL, 12, `MODE_ACTIVE);
		// Clock enable low: a hot battery must not be seen until it rises again
		ce <= 1'b0;
		scene <= NORMAL | 15'h0080;
		cyc(12);
		chk(mode, `MODE_ACTIVE);
		chk(chg_en, 1'b1);
		ce <= 1'b1;
		cyc(12);
		chk(mode, `MODE_STANDBY);
		settle(NORMAL, 12, `MODE_ACTIVE);
		// Software hold-off, read back, then a software restart
		bus(32'h0000_0000, 1'b1, 32'h0000_0002);
		cyc(4);
		chk(mode, `MODE_STANDBY);
		chk(chg_en, 1'b0);
		bus(32'h0000_0000, 1'b0, 32'h0000_0000);
		chk(rdata, 32'h0000_0002);
		bus(32'h0000_0000, 1'b1, 32'h0000_0001);
		cyc(1);
		chk(mode, `MODE_SHUTDOWN);
		cyc(4);
		chk(mode, `MODE_ACTIVE);
		chk(chg_en, 1'b1);
		foreach (latches[i]) begin
			scene <= NORMAL | latches[i];
			poke;
			cyc(4020);
			chk(chg_en, 1'b0);
			check_blink;
			scene <= NORMAL;
			cyc(12);
			chk(chg_en, 1'b0);
			bus(32'h0000_000C, 1'b0, 32'h0000_0000);
			if (latches[i][10]) chk(rdata, 32'h0000_0000);
			poke;
			chk(mode, `MODE_ACTIVE);
		end
		scene <= 15'h6020;
		poke;
		cyc(4880);
		chk(expired, 1'b0);
		cyc(200);
		chk(expired, 1'b1);
		check_blink;
		scene <= 15'h6220;
		poke;
		cyc(9780);
		chk(expired, 1'b0);
		cyc(400);
		chk(expired, 1'b1);
		repeat (8) begin
			lfsr = lfsr_next(lfsr);
			s = 15'h0004 | (lfsr[14:0] & 15'h78E0);
			if (!s[13]) s = s & 15'h6024;
			poke;
			settle(s, s[12] ? 4020 : 12, exp_mode(s));
		end
		bus(32'h0000_0010, 1'b1, 32'hFFFF_FFFF);
		bus(32'h0000_0010, 1'b0, 32'h0000_0000);
		chk(rdata, 32'h0000_0000);
		results;
	end
endmodule // charger_ctrl_tb_top
